// file: rtl/dpc_pkg.sv
package dpc_pkg;
   // clock period in ns at 20 MHz
   localparam int CLK_NS = 50;
   // speed grade selection codes
   localparam logic [1:0] GRADE_FAST = 2'h0;
   localparam logic [1:0] GRADE_MID = 2'h1;
   localparam logic [1:0] GRADE_SLOW = 2'h2;
   // geometry
   localparam int ADDR_W = 7;
   localparam int CELL_W = 14;
   localparam int BANKS = 4;
   localparam int BANK_W = 2;
   localparam int ROWS = 128;
   localparam int INIT_CYCLES = 8;
   // least times in ns, per grade fast, mid, slow
   localparam int T_PAGE_NS [3] = '{170, 225, 275};
   localparam int T_RC_NS [3] = '{375, 375, 410};
   localparam int T_RMW_NS [3] = '{375, 375, 515};
   localparam int T_CP_NS [3] = '{60, 80, 100};
   localparam int T_CAS_NS [3] = '{100, 135, 165};
   localparam int T_RP_NS [3] = '{100, 120, 150};
   localparam int T_RAS_NS [3] = '{150, 200, 250};
   localparam int T_RSH_NS [3] = '{100, 135, 165};
   localparam int T_RCD_NS [3] = '{20, 25, 35};
   // longest strobe low time and refresh period
   localparam int T_STROBE_MAX_NS = 10000;
   localparam int T_REF_NS = 2000000;
   // cycle counts: minima round up, maxima round down
   localparam int STROBE_MAX_CYC = T_STROBE_MAX_NS / CLK_NS;
   localparam int REF_ROW_CYC = T_REF_NS / ROWS / CLK_NS;
   localparam int CNT_W = 10;
   // margin kept before the maximum low time so a row cycle closes in time
   localparam int STROBE_GUARD_CYC = 20;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_RAS = 4'h1,
      ST_CAS = 4'h2,
      ST_CPRE = 4'h3,
      ST_HOLD = 4'h4,
      ST_RPRE = 4'h5,
      ST_REF = 4'h6
   } dpc_state_t;
endpackage

// file: rtl/dpc_ctrl.sv
`timescale 1ns/10ps
// Behaviour
// R1 - hold row strobe low and issue column strobes for a page burst
// R2 - row strobe common to all RAMs, column strobe decoded per RAM
// R3 - eight row strobe cycles after reset before any access
// R4 - successive column strobe cycles spaced by the page cycle minimum
// R5 - full row cycle lasts at least the read/write or RMW minimum
// R6 - column strobe stays high for its precharge minimum
// R7 - column strobe low at least access time, never over 10 us
// R8 - row strobe stays high for its precharge minimum
// R9 - row strobe low at least its minimum, never over 10 us
// R10 - row strobe stays low long enough after last column strobe fall
// R11 - row to column strobe delay meets its minimum
// R12 - whole memory refreshed at least every two milliseconds
// R13 - refresh walks all 128 row addresses with the row strobe
// R14 - column strobes stay high during row-only refresh
// R15 - row half then column half put on seven muxed address lines
// R16 - minima counted in whole clocks, row cycle ended before maximum
// R17 - refresh takes priority over pending accesses and long bursts
module dpc_ctrl
   import dpc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [1:0] grade,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic req_rmw,
   input wire logic req_last,
   input wire logic [BANK_W-1:0] req_bank,
   input wire logic [CELL_W-1:0] req_addr,
   input wire logic req_wdata,
   output logic rd_valid,
   output logic rd_data,
   output logic init_done,
   output logic [ADDR_W-1:0] muxed_address_lines,
   output logic ras_n,
   output logic [BANKS-1:0] cas_n,
   output logic we_n,
   output logic din,
   input wire logic [BANKS-1:0] dout
);
   // cycles from ns, rounded up, at least one
   function automatic logic [CNT_W-1:0] cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      if (c < 1) c = 1;
      return CNT_W'(c);
   endfunction
   // grade index clamped to the three documented grades
   function automatic int gi(input logic [1:0] g);
      return (g > GRADE_SLOW) ? 2 : int'(g);
   endfunction

   logic [CNT_W-1:0] c_page, c_rc, c_cp, c_cas, c_rp, c_ras, c_rsh, c_rcd;
   // per-grade minimum counts
   always_comb begin
      c_page = cyc(T_PAGE_NS[gi(grade)]);
      c_rc = req_rmw ? cyc(T_RMW_NS[gi(grade)]) : cyc(T_RC_NS[gi(grade)]);
      c_cp = cyc(T_CP_NS[gi(grade)]);
      c_cas = cyc(T_CAS_NS[gi(grade)]);
      c_rp = cyc(T_RP_NS[gi(grade)]);
      c_ras = cyc(T_RAS_NS[gi(grade)]);
      c_rsh = cyc(T_RSH_NS[gi(grade)]);
      c_rcd = cyc(T_RCD_NS[gi(grade)]);
   end

   dpc_state_t state_r, state_nxt;
   logic [CNT_W-1:0] tmr_r, tmr_nxt; // time in current phase
   logic [CNT_W-1:0] ras_t_r, ras_t_nxt; // time since row strobe fell
   logic [CNT_W-1:0] page_t_r, page_t_nxt; // time since column strobe fell
   logic [CNT_W-1:0] cyc_min_r, cyc_min_nxt;
   logic [3:0] init_cnt_r, init_cnt_nxt;
   logic [15:0] ref_tmr_r, ref_tmr_nxt;
   logic ref_due_r, ref_due_nxt;
   logic [ADDR_W-1:0] ref_row_r, ref_row_nxt;
   logic [ADDR_W-1:0] open_row_r, open_row_nxt;
   logic [BANK_W-1:0] bank_r, bank_nxt;
   logic wr_r, wr_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic ras_n_r, ras_n_nxt;
   logic [BANKS-1:0] cas_n_r, cas_n_nxt;
   logic we_n_r, we_n_nxt;
   logic din_r, din_nxt;
   logic rdv_r, rdv_nxt;
   logic rdd_r, rdd_nxt;
   logic last_r, last_nxt; // taken access closes the row
   logic init_done_r;
   logic hit, near_max;

   assign init_done_r = (init_cnt_r == 4'(INIT_CYCLES));
   assign hit = req_valid && (req_addr[CELL_W-1:ADDR_W] == open_row_r);
   assign near_max = ras_t_r >= CNT_W'(STROBE_MAX_CYC - STROBE_GUARD_CYC);
   // request taken only when a row strobe (from idle) or an open-row column strobe can start now
   assign req_ready = init_done_r && !ref_due_r &&
                      ((state_r == ST_IDLE && tmr_r >= c_rp) ||
                       (state_r == ST_CPRE && hit && !near_max &&
                        tmr_r >= c_cp && page_t_r >= c_page));

   // refresh pacing: one row every 2 ms / 128
   always_comb begin
      ref_tmr_nxt = ref_tmr_r + 16'h0001;
      ref_due_nxt = ref_due_r;
      // clear first, so a new tick in the same cycle is not lost
      if (state_r == ST_REF && tmr_r == 0)
         ref_due_nxt = 1'b0;
      if (ref_tmr_r == 16'(REF_ROW_CYC - 1)) begin
         ref_tmr_nxt = 16'h0000;
         ref_due_nxt = 1'b1; // [R12]
      end
   end

   // strobe sequencer
   always_comb begin
      state_nxt = state_r;
      tmr_nxt = (tmr_r == '1) ? tmr_r : tmr_r + 1'b1;
      ras_t_nxt = (ras_t_r == '1) ? ras_t_r : ras_t_r + 1'b1;
      page_t_nxt = (page_t_r == '1) ? page_t_r : page_t_r + 1'b1;
      cyc_min_nxt = cyc_min_r;
      init_cnt_nxt = init_cnt_r;
      ref_row_nxt = ref_row_r;
      open_row_nxt = open_row_r;
      bank_nxt = bank_r;
      wr_nxt = wr_r;
      addr_nxt = addr_r;
      ras_n_nxt = ras_n_r;
      cas_n_nxt = cas_n_r;
      we_n_nxt = we_n_r;
      din_nxt = din_r;
      rdv_nxt = 1'b0;
      rdd_nxt = rdd_r;
      last_nxt = last_r;
      unique case (state_r)
         ST_IDLE: begin
            if (tmr_r >= c_rp) begin // [R8]
               if (!init_done_r || ref_due_r) begin // [R3] [R17]
                  addr_nxt = ref_row_r; // [R13]
                  ras_n_nxt = 1'b0;
                  cas_n_nxt = '1; // [R14]
                  state_nxt = ST_REF;
                  tmr_nxt = '0;
                  ras_t_nxt = '0;
                  cyc_min_nxt = c_rc;
               end else if (req_valid) begin
                  open_row_nxt = req_addr[CELL_W-1:ADDR_W];
                  addr_nxt = req_addr[CELL_W-1:ADDR_W]; // [R15]
                  bank_nxt = req_bank;
                  wr_nxt = req_write;
                  we_n_nxt = !req_write;
                  din_nxt = req_wdata;
                  last_nxt = req_last;
                  ras_n_nxt = 1'b0; // [R2]
                  state_nxt = ST_RAS;
                  tmr_nxt = '0;
                  ras_t_nxt = '0;
                  cyc_min_nxt = c_rc; // [R5]
               end
            end
         end
         ST_RAS: begin
            if (tmr_r == 0)
               addr_nxt = req_addr[ADDR_W-1:0]; // [R15]
            if (tmr_r + 1'b1 >= c_rcd) begin // [R11]
               cas_n_nxt[bank_r] = 1'b0; // [R2]
               state_nxt = ST_CAS;
               tmr_nxt = '0;
               page_t_nxt = '0;
            end
         end
         ST_CAS: begin
            if (tmr_r + 1'b1 >= c_cas) begin // [R7] [R16]
               if (!wr_r) begin
                  rdv_nxt = 1'b1;
                  rdd_nxt = dout[bank_r];
               end
               cas_n_nxt = '1;
               we_n_nxt = 1'b1;
               state_nxt = ST_CPRE;
               tmr_nxt = '0;
            end
         end
         ST_CPRE: begin
            if (req_ready && req_valid) begin // [R1] [R4] [R6]
               addr_nxt = req_addr[ADDR_W-1:0];
               bank_nxt = req_bank;
               wr_nxt = req_write;
               we_n_nxt = !req_write;
               din_nxt = req_wdata;
               last_nxt = req_last;
               cas_n_nxt[req_bank] = 1'b0; // [R2]
               state_nxt = ST_CAS;
               tmr_nxt = '0;
               page_t_nxt = '0;
            end else if ((req_valid && !hit) || ref_due_r || near_max || last_r) begin
               state_nxt = ST_HOLD; // [R9] [R17]
            end
         end
         ST_HOLD: begin
            if (page_t_r >= c_rsh && ras_t_r >= c_ras && ras_t_r >= cyc_min_r - c_rp) begin
               ras_n_nxt = 1'b1; // [R10] [R9] [R5]
               state_nxt = ST_IDLE;
               tmr_nxt = '0;
            end
         end
         ST_REF: begin
            if (tmr_r + 1'b1 >= c_ras) begin // [R9]
               ras_n_nxt = 1'b1;
               ref_row_nxt = ref_row_r + 1'b1;
               if (!init_done_r)
                  init_cnt_nxt = init_cnt_r + 4'h1; // [R3]
               state_nxt = ST_RPRE;
               tmr_nxt = '0;
            end
         end
         ST_RPRE: begin
            if (tmr_r + 1'b1 >= cyc_min_r - c_ras) begin // [R5]
               state_nxt = ST_IDLE;
               tmr_nxt = c_rp; // precharge already served here
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            ras_n_nxt = 1'b1;
            cas_n_nxt = '1;
         end
      endcase
   end

   // registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         tmr_r <= '0;
         ras_t_r <= '0;
         page_t_r <= '0;
         cyc_min_r <= '0;
         init_cnt_r <= 4'h0;
         ref_tmr_r <= 16'h0000;
         ref_due_r <= 1'b0;
         ref_row_r <= '0;
         open_row_r <= '0;
         bank_r <= '0;
         wr_r <= 1'b0;
         addr_r <= '0;
         ras_n_r <= 1'b1;
         cas_n_r <= '1;
         we_n_r <= 1'b1;
         din_r <= 1'b0;
         rdv_r <= 1'b0;
         rdd_r <= 1'b0;
         last_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         tmr_r <= tmr_nxt;
         ras_t_r <= ras_t_nxt;
         page_t_r <= page_t_nxt;
         cyc_min_r <= cyc_min_nxt;
         init_cnt_r <= init_cnt_nxt;
         ref_tmr_r <= ref_tmr_nxt;
         ref_due_r <= ref_due_nxt;
         ref_row_r <= ref_row_nxt;
         open_row_r <= open_row_nxt;
         bank_r <= bank_nxt;
         wr_r <= wr_nxt;
         addr_r <= addr_nxt;
         ras_n_r <= ras_n_nxt;
         cas_n_r <= cas_n_nxt;
         we_n_r <= we_n_nxt;
         din_r <= din_nxt;
         rdv_r <= rdv_nxt;
         rdd_r <= rdd_nxt;
         last_r <= last_nxt;
      end
   end

   assign muxed_address_lines = addr_r;
   assign ras_n = ras_n_r;
   assign cas_n = cas_n_r;
   assign we_n = we_n_r;
   assign din = din_r;
   assign rd_valid = rdv_r;
   assign rd_data = rdd_r;
   assign init_done = init_done_r;
endmodule // dpc_ctrl

// file: test/dpc_ctrl_monitor.sv
`timescale 1ns/10ps
module dpc_ctrl_monitor
   import dpc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [1:0] grade,
   input wire logic req_ready,
   input wire logic init_done,
   input wire logic ras_n,
   input wire logic [BANKS-1:0] cas_n
);
   logic [9:0] rh_r, rl_r, ch_r, cl_r, cf_r, rf_r;
   logic [9:0] rh_nxt, rl_nxt, ch_nxt, cl_nxt, cf_nxt, rf_nxt;
   logic cq_r, rq_r;
   int gi;
   wire logic ca = &cas_n;
   function automatic int mc(input int ns);
      return (ns + CLK_NS - 1) / CLK_NS;
   endfunction
   function automatic logic [9:0] up(input logic [9:0] v);
      return (&v) ? v : v + 10'h1;
   endfunction
   // run length of each strobe level and spacing of strobe falls
   always_comb begin
      gi = (grade == 2'h3) ? 2 : int'(grade);
      rh_nxt = ras_n ? up(rh_r) : 10'h0;
      rl_nxt = ras_n ? 10'h0 : up(rl_r);
      ch_nxt = ca ? up(ch_r) : 10'h0;
      cl_nxt = ca ? 10'h0 : up(cl_r);
      cf_nxt = (cq_r && !ca) ? 10'h1 : up(cf_r);
      rf_nxt = (rq_r && !ras_n) ? 10'h1 : up(rf_r);
   end
   // counter registers, long idle assumed out of reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         {rh_r, ch_r, cf_r, rf_r} <= '1;
         {rl_r, cl_r} <= '0;
         {cq_r, rq_r} <= 2'h3;
      end else begin
         {rh_r, rl_r, ch_r, cl_r, cf_r, rf_r} <= {rh_nxt, rl_nxt, ch_nxt, cl_nxt, cf_nxt, rf_nxt};
         {cq_r, rq_r} <= {ca, ras_n};
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_ras_precharge: assert property ($fell(ras_n) |-> rh_r >= mc(T_RP_NS[gi]))
      else $error("row strobe precharge too short");
   a_ras_low_min: assert property ($rose(ras_n) |-> rl_r >= mc(T_RAS_NS[gi]))
      else $error("row strobe pulse too short");
   a_ras_low_max: assert property (!ras_n |-> rl_r < STROBE_MAX_CYC)
      else $error("row strobe pulse too long");
   a_cas_low_min: assert property ($rose(ca) |-> cl_r >= mc(T_CAS_NS[gi]))
      else $error("column strobe pulse too short");
   a_cas_precharge: assert property ($fell(ca) |-> ch_r >= mc(T_CP_NS[gi]))
      else $error("column strobe precharge too short");
   a_cas_one_bank: assert property (!ca |-> $onehot(~cas_n) && !ras_n)
      else $error("column strobe outside row or not one bank");
   a_row_to_col: assert property ($fell(ca) |-> rl_r >= mc(T_RCD_NS[gi]))
      else $error("row to column delay too short");
   a_ras_hold: assert property ($rose(ras_n) |-> cf_r >= mc(T_RSH_NS[gi]))
      else $error("row closed too soon after column strobe");
   a_page_cycle: assert property ($fell(ca) |-> cf_r >= mc(T_PAGE_NS[gi]))
      else $error("page cycle too short");
   a_row_cycle: assert property ($fell(ras_n) |-> rf_r >= mc(T_RC_NS[gi]))
      else $error("row cycle too short");
   a_init_first: assert property (!init_done |-> ca && !req_ready)
      else $error("access before init cycles");
endmodule // dpc_ctrl_monitor
bind dpc_ctrl dpc_ctrl_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n), .grade(grade),
   .req_ready(req_ready), .init_done(init_done), .ras_n(ras_n), .cas_n(cas_n));

// file: test/dpc_ram_model.sv
`timescale 1ns/10ps
module dpc_ram_model
   import dpc_pkg::*;
#(
   parameter int ACC_NS = 100
)
(
   input wire logic ras_n,
   input wire logic [BANKS-1:0] cas_n,
   input wire logic [ADDR_W-1:0] muxed_address_lines,
   input wire logic we_n,
   input wire logic din,
   output logic [BANKS-1:0] dout
);
   logic mem [BANKS][1<<CELL_W];
   logic [ADDR_W-1:0] row_r;
   logic [ROWS-1:0] seen = '0;
   realtime last [ROWS];
   int ras_cnt = 0;
   int fault_cnt = 0;
   initial dout = '0;
   // row half latched after the row strobe falls, refresh age checked
   always @(negedge ras_n) begin
      #1;
      row_r = muxed_address_lines;
      ras_cnt++;
      if (seen[row_r] && ($realtime - last[row_r] > T_REF_NS)) fault_cnt++;
      seen[row_r] = 1'b1;
      last[row_r] = $realtime;
   end
   // each ram owns one column strobe; output inverts when it rises
   for (genvar b = 0; b < BANKS; b++) begin : g_bank
      always @(negedge cas_n[b]) begin
         #1;
         if (ras_cnt <= INIT_CYCLES) fault_cnt++;
         if (!we_n) mem[b][{row_r, muxed_address_lines}] = din;
         // valid just inside the access time, so the strobe end samples it
         else dout[b] <= #(ACC_NS - 2) mem[b][{row_r, muxed_address_lines}];
      end
      always @(posedge cas_n[b]) dout[b] = ~dout[b];
   end
endmodule // dpc_ram_model

// file: test/testbench.sv
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
   import dpc_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] grade = GRADE_FAST;
   logic req_valid = 1'b0, req_write = 1'b0, req_rmw = 1'b0, req_last = 1'b0, req_wdata = 1'b0;
   logic [BANK_W-1:0] req_bank = '0;
   logic [CELL_W-1:0] req_addr = '0;
   logic req_ready, rd_valid, rd_data, init_done, ras_n, we_n, din;
   logic [ADDR_W-1:0] muxed_address_lines;
   logic [BANKS-1:0] cas_n, dout;
   int n_mismatch = 0;
   int samples_checked = 0;
   always #25 core_clk = ~core_clk;
   dpc_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n), .grade(grade), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_rmw(req_rmw), .req_last(req_last),
      .req_bank(req_bank), .req_addr(req_addr), .req_wdata(req_wdata), .rd_valid(rd_valid),
      .rd_data(rd_data), .init_done(init_done), .muxed_address_lines(muxed_address_lines),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .din(din), .dout(dout));
   dpc_ram_model ram (.ras_n(ras_n), .cas_n(cas_n), .muxed_address_lines(muxed_address_lines),
      .we_n(we_n), .din(din), .dout(dout));
   task automatic test_done();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic fail_out();
      n_mismatch++;
      test_done();
   endtask
   function automatic logic pat(input logic [BANK_W-1:0] b, input logic [CELL_W-1:0] a);
      return ^{b, a, grade};
   endfunction
   // reset two cycles at a grade, then wait for the init row cycles
   task automatic start(input logic [1:0] g);
      int i, base;
      @(posedge core_clk);
      rst_n <= 1'b0;
      grade <= g;
      repeat (2) @(posedge core_clk);
      `CHK({ras_n, cas_n, we_n, init_done, req_ready}, 8'hfc)
      base = ram.ras_cnt;
      rst_n <= 1'b1;
      for (i = 0; i < 400 && init_done !== 1'b1; i++) @(posedge core_clk);
      if (i == 400) fail_out();
      `CHK(ram.ras_cnt - base >= INIT_CYCLES, 1'b1)
   endtask
   // one access held until taken; a read waits for its data
   task automatic acc(input logic w, input logic [BANK_W-1:0] b, input logic [CELL_W-1:0] a,
      input logic last, input logic rmw);
      int i;
      @(posedge core_clk);
      req_valid <= 1'b1;
      {req_write, req_bank, req_addr, req_wdata, req_last, req_rmw} <= {w, b, a, pat(b, a), last, rmw};
      for (i = 0; i < 2000; i++) begin
         @(negedge core_clk);
         if (req_ready === 1'b1) break;
      end
      if (i == 2000) fail_out();
      @(posedge core_clk);
      req_valid <= 1'b0;
      if (!w) begin
         for (i = 0; i < 50; i++) begin
            @(negedge core_clk);
            if (rd_valid === 1'b1) break;
         end
         if (i == 50) fail_out();
         `CHK(rd_data, pat(b, a))
      end
   endtask
   // same cell in every ram, told apart by the decoded column strobe
   task automatic t_banks();
      for (int b = 0; b < BANKS; b++) acc(1'b1, b[1:0], 14'h2aaa, 1'b1, 1'b0);
      for (int b = 0; b < BANKS; b++) acc(1'b0, b[1:0], 14'h2aaa, 1'b1, 1'b0);
   endtask
   // column burst in one open row, last column at the top boundary
   // one refresh may split the row: its own row plus one reopen
   task automatic t_page(input logic rmw);
      int base;
      base = ram.ras_cnt;
      for (int c = 0; c < 6; c++) acc(1'b1, 2'h1, {7'h3c, 7'(c * 25 + 2)}, c == 5, 1'b0);
      `CHK(ram.ras_cnt - base <= 3, 1'b1)
      base = ram.ras_cnt;
      for (int c = 0; c < 6; c++) acc(1'b0, 2'h1, {7'h3c, 7'(c * 25 + 2)}, c == 5, rmw);
      `CHK(ram.ras_cnt - base <= 3, 1'b1)
   endtask
   // idle run longer than one refresh sweep: rows only, every row in time
   task automatic t_refresh();
      repeat (ROWS * REF_ROW_CYC + 500) begin
         @(negedge core_clk);
         `CHK(cas_n, 4'hf)
      end
      `CHK(&ram.seen, 1'b1)
      `CHK(ram.fault_cnt, 0)
   endtask
   initial begin
      for (int g = 0; g < 3; g++) begin
         start(g[1:0]);
         t_banks();
         t_page(g != 0);
      end
      t_refresh();
      test_done();
   end
endmodule // testbench
